// file: src/phy_control_status_regs.sv
`timescale 1ns/1ps
`include "phy_regs_map.svh"
// What this block does
// - Isolate bit set tri-states the MII outputs; resets to zero.
// - Writing one to restart bit restarts autonegotiation; resets to zero.
// - Restart bit going high clears the negotiation-complete flag.
// - Restart bit self-clears once autonegotiation has actually restarted.
// - Duplex bit: one full, zero half; ignored while negotiation enabled.
// - With negotiation disabled, effective duplex is duplex bit ORed with the full-duplex strap.
// - Collision test echoes transmit enable onto internal collision only.
// - Control bits six to zero always read zero.
// - Ability bits fixed: four-pair zero, other four abilities one.
// - Status bits ten to seven always read zero.
// - Preamble-suppress bit reads one when preambleless frames are accepted.
// - Negotiation-complete set only when finished; resets zero; clears on start.
// - Remote fault latches high until the status register is read.
// - Negotiation ability bit always reads one.
// - Link failure latches link bit low until status is read.
// - Jabber latches high; clears only after read and condition gone.
// - Extended capability bit always reads one.
// - Negotiation enable resets to one, gated by the strap level.
module phy_control_status_regs #(
    parameter bit PREAMBLE_SUPPRESS = 1'b1,
    parameter int PREAMBLE_LEN = `MDIO_PREAMBLE_LEN
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic mdc, // Management clock pin
    input wire logic mdioIn, // Management data pin, input side
    output logic mdioOut, // Management data pin, output side
    output logic mdioOe, // Management data output enable
    input wire logic [4:0] phyAddrStrap, // Port address straps
    input wire logic strapAutoEn, // Autonegotiation strap
    input wire logic strapFullDup, // Full-duplex strap
    input wire logic linkValid, // Link currently valid
    input wire logic remoteFault, // Remote fault seen
    input wire logic jabberDetect, // Jabber condition present
    input wire logic negDoneIn, // Negotiation finished pulse
    input wire logic negRestartedIn, // Negotiation restarted pulse
    input wire logic anFullDuplexIn, // Negotiated duplex result
    input wire logic transmitEnableIn, // Transmit enable
    output logic negotiationRestartReq, // Restart request level
    output logic negotiationEnableOut, // Negotiation enabled
    output logic fullDuplexOut, // Effective duplex
    output logic collisionOut, // Internal collision
    output logic miiDriveEn // MII outputs enabled
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pin_sync_if #(.W(`PIN_SYNC_WIDTH)) pinBus ();

    assign pinBus.raw = {mdc, mdioIn, strapAutoEn, strapFullDup, phyAddrStrap};

    pin_sync #(.W(`PIN_SYNC_WIDTH)) uPinSync (
        .clk(clk),
        .rst_b(rst_b),
        .pins(pinBus.sync)
    );

    logic mdcS, mdioS, autoEnS, fullDupS;
    logic [4:0] phyAddrS;
    assign {mdcS, mdioS, autoEnS, fullDupS, phyAddrS} = pinBus.synced;

    if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 63) begin : g_bad_preamble
        $error("PREAMBLE_LEN must be between 1 and 63");
    end

    localparam logic [5:0] PRE_COUNT = 6'(PREAMBLE_LEN);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic negotiationEnable_r, isolate_r, negotiationRestart_r;
    logic duplexSelect_r, collisionTest_r;
    logic negotiationComplete_r, farFaultFlag_r, linkUpLatched_r, jabber_r;
    logic mdcPrev_r;
    logic mdcRise;
    logic [15:0] controlWord, statusWord, readWord;

    assign mdcRise = mdcS & ~mdcPrev_r;

    always_comb begin
        controlWord = 16'h0000;
        controlWord[`CTL_NEG_ENABLE] = negotiationEnable_r;
        controlWord[`CTL_ISOLATE] = isolate_r;
        controlWord[`CTL_NEG_RESTART] = negotiationRestart_r;
        controlWord[`CTL_DUPLEX] = duplexSelect_r;
        controlWord[`CTL_COL_TEST] = collisionTest_r;
    end

    always_comb begin
        statusWord = 16'h0000;
        statusWord[`STS_FOUR_PAIR] = 1'b0;
        statusWord[`STS_FAST_FD] = 1'b1;
        statusWord[`STS_FAST_HD] = 1'b1;
        statusWord[`STS_TEN_FD] = 1'b1;
        statusWord[`STS_TEN_HD] = 1'b1;
        statusWord[`STS_PRE_SUPPRESS] = PREAMBLE_SUPPRESS;
        statusWord[`STS_NEG_COMPLETE] = negotiationComplete_r;
        statusWord[`STS_FAR_FAULT] = farFaultFlag_r;
        statusWord[`STS_NEG_ABILITY] = 1'b1;
        statusWord[`STS_LINK_UP] = linkUpLatched_r;
        statusWord[`STS_JABBER] = jabber_r;
        statusWord[`STS_EXT_REGS] = 1'b1;
    end

    // ----------------------------------------------------------------
    // Management frame engine
    // ----------------------------------------------------------------
    phy_regs_pkg::frame_state_t state_r;
    logic [5:0] preCnt_r;
    logic [3:0] bitCnt_r;
    logic [1:0] opSh_r;
    logic [9:0] addrSh_r;
    logic [15:0] dataSh_r;
    logic [4:0] regAddr_r;
    logic isRead_r, hit_r;
    logic wrPulse_r, rdDone_r;
    logic [15:0] wrData_r;
    logic [9:0] addrNext;
    logic preambleOk;

    assign addrNext = {addrSh_r[8:0], mdioS};
    assign preambleOk = PREAMBLE_SUPPRESS || (preCnt_r >= PRE_COUNT);
    // Registers past index one belong to other blocks and read as zero here
    assign readWord = (addrNext[4:0] == `REG_PORT_CONTROL) ? controlWord :
                      (addrNext[4:0] == `REG_PORT_BASIC_STATUS) ? statusWord : 16'h0000;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mdcPrev_r <= 1'b0;
        end else begin
            mdcPrev_r <= mdcS;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= phy_regs_pkg::FR_IDLE;
            preCnt_r <= 6'h00;
            bitCnt_r <= 4'h0;
            opSh_r <= 2'h0;
            addrSh_r <= 10'h000;
            dataSh_r <= 16'h0000;
            regAddr_r <= 5'h00;
            isRead_r <= 1'b0;
            hit_r <= 1'b0;
            wrPulse_r <= 1'b0;
            rdDone_r <= 1'b0;
            wrData_r <= 16'h0000;
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
        end else begin
            wrPulse_r <= 1'b0;
            rdDone_r <= 1'b0;
            if (mdcRise) begin
                case (state_r)
                    phy_regs_pkg::FR_IDLE: begin
                        if (mdioS) begin
                            if (preCnt_r != 6'h3F) begin
                                preCnt_r <= preCnt_r + 6'h01;
                            end
                        end else begin
                            preCnt_r <= 6'h00;
                            // short preamble accepted only when suppression allowed
                            if (preambleOk) begin
                                state_r <= phy_regs_pkg::FR_START;
                            end
                        end
                    end
                    phy_regs_pkg::FR_START: begin
                        bitCnt_r <= 4'h0;
                        state_r <= mdioS ? phy_regs_pkg::FR_OPCODE : phy_regs_pkg::FR_IDLE;
                    end
                    phy_regs_pkg::FR_OPCODE: begin
                        opSh_r <= {opSh_r[0], mdioS};
                        if (bitCnt_r == 4'h1) begin
                            bitCnt_r <= 4'h0;
                            isRead_r <= ({opSh_r[0], mdioS} == phy_regs_pkg::OP_READ);
                            if ({opSh_r[0], mdioS} == phy_regs_pkg::OP_READ ||
                                {opSh_r[0], mdioS} == phy_regs_pkg::OP_WRITE) begin
                                state_r <= phy_regs_pkg::FR_ADDR;
                            end else begin
                                state_r <= phy_regs_pkg::FR_IDLE;
                            end
                        end else begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                    phy_regs_pkg::FR_ADDR: begin
                        addrSh_r <= addrNext;
                        if (bitCnt_r == `MDIO_ADDR_BITS) begin
                            bitCnt_r <= 4'h0;
                            hit_r <= (addrNext[9:5] == phyAddrS);
                            regAddr_r <= addrNext[4:0];
                            // snapshot taken before any latch release
                            dataSh_r <= readWord;
                            state_r <= phy_regs_pkg::FR_TURN;
                        end else begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                    phy_regs_pkg::FR_TURN: begin
                        if (bitCnt_r == `MDIO_TA_FIRST) begin
                            bitCnt_r <= 4'h1;
                            if (hit_r && isRead_r) begin
                                mdioOe <= 1'b1;
                                mdioOut <= 1'b0;
                            end
                        end else begin
                            bitCnt_r <= 4'h0;
                            state_r <= phy_regs_pkg::FR_DATA;
                            if (hit_r && isRead_r) begin
                                mdioOut <= dataSh_r[15];
                                dataSh_r <= {dataSh_r[14:0], 1'b0};
                            end
                        end
                    end
                    phy_regs_pkg::FR_DATA: begin
                        if (isRead_r) begin
                            mdioOut <= dataSh_r[15];
                            dataSh_r <= {dataSh_r[14:0], 1'b0};
                        end else begin
                            dataSh_r <= {dataSh_r[14:0], mdioS};
                        end
                        if (bitCnt_r == `MDIO_LAST_BIT) begin
                            bitCnt_r <= 4'h0;
                            mdioOe <= 1'b0;
                            mdioOut <= 1'b0;
                            state_r <= phy_regs_pkg::FR_IDLE;
                            wrPulse_r <= hit_r & ~isRead_r;
                            wrData_r <= {dataSh_r[14:0], mdioS};
                            rdDone_r <= hit_r & isRead_r &
                                        (regAddr_r == `REG_PORT_BASIC_STATUS);
                        end else begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                    default: begin
                        state_r <= phy_regs_pkg::FR_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic wrCtrl, restartWrite;
    assign wrCtrl = wrPulse_r && (regAddr_r == `REG_PORT_CONTROL);
    assign restartWrite = wrCtrl && wrData_r[`CTL_NEG_RESTART];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // enable defaults on, gated by strap
            negotiationEnable_r <= autoEnS;
            isolate_r <= 1'b0;
            duplexSelect_r <= 1'b0;
            collisionTest_r <= 1'b0;
        end else if (wrCtrl) begin
            negotiationEnable_r <= wrData_r[`CTL_NEG_ENABLE];
            isolate_r <= wrData_r[`CTL_ISOLATE];
            duplexSelect_r <= wrData_r[`CTL_DUPLEX];
            collisionTest_r <= wrData_r[`CTL_COL_TEST];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            negotiationRestart_r <= 1'b0;
        // restart request, set wins over acknowledge
        end else if (restartWrite) begin
            negotiationRestart_r <= 1'b1;
        end else if (negRestartedIn) begin
            negotiationRestart_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Port outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            miiDriveEn <= 1'b1;
            negotiationRestartReq <= 1'b0;
            negotiationEnableOut <= 1'b0;
            fullDuplexOut <= 1'b0;
            collisionOut <= 1'b0;
        end else begin
            miiDriveEn <= ~isolate_r;
            negotiationRestartReq <= negotiationRestart_r;
            negotiationEnableOut <= negotiationEnable_r;
            fullDuplexOut <= negotiationEnable_r ? anFullDuplexIn : (duplexSelect_r | fullDupS);
            collisionOut <= collisionTest_r & transmitEnableIn;
        end
    end

    // ----------------------------------------------------------------
    // Status latches
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            negotiationComplete_r <= 1'b0;
        // clear on start, set when done
        end else if (restartWrite || negRestartedIn) begin
            negotiationComplete_r <= 1'b0;
        end else if (negDoneIn) begin
            negotiationComplete_r <= 1'b1;
        end
    end

    // A release in the read-done cycle re-samples the live level, so events win
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            farFaultFlag_r <= 1'b0;
            linkUpLatched_r <= 1'b0;
            jabber_r <= 1'b0;
        end else begin
            farFaultFlag_r <= rdDone_r ? remoteFault : (farFaultFlag_r | remoteFault);
            linkUpLatched_r <= rdDone_r ? linkValid : (linkUpLatched_r & linkValid);
            jabber_r <= rdDone_r ? jabberDetect : (jabber_r | jabberDetect);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence seq_restartWrite;
        restartWrite;
    endsequence

    sequence seq_restartAck;
        negotiationRestart_r && negRestartedIn && !restartWrite;
    endsequence

    chk_isolate_drive: assert property (
        wrCtrl |=> ##1 (miiDriveEn == !$past(wrData_r[`CTL_ISOLATE], 2)))
        else $error("MII drive enable does not follow isolate");
    chk_restart_req: assert property (
        seq_restartWrite |=> ##1 negotiationRestartReq)
        else $error("restart write did not raise request");
    chk_restart_clears_done: assert property (
        seq_restartWrite |=> !negotiationComplete_r)
        else $error("negotiation complete not cleared by restart");
    chk_restart_selfclear: assert property (
        seq_restartAck |=> !negotiationRestart_r ##1 !negotiationRestartReq)
        else $error("restart bit did not self-clear");
    chk_duplex_forced: assert property (
        !negotiationEnable_r |=> (fullDuplexOut == ($past(duplexSelect_r) | $past(fullDupS))))
        else $error("forced duplex mismatch");
    chk_duplex_negotiated: assert property (
        negotiationEnable_r |=> (fullDuplexOut == $past(anFullDuplexIn)))
        else $error("duplex bit not ignored while negotiating");
    chk_collision_echo: assert property (
        collisionTest_r && transmitEnableIn |=> collisionOut)
        else $error("collision test echo missing");
    chk_far_fault_hold: assert property (
        farFaultFlag_r && !rdDone_r |=> farFaultFlag_r)
        else $error("far fault released without read");
    chk_link_low_hold: assert property (
        !linkUpLatched_r && !rdDone_r |=> !linkUpLatched_r)
        else $error("link bit recovered without read");
    chk_jabber_hold: assert property (
        jabber_r && (!rdDone_r || jabberDetect) |=> jabber_r)
        else $error("jabber released early");
    chk_read_release: assert property (
        rdDone_r |-> !mdioOe ##1 (linkUpLatched_r == $past(linkValid)))
        else $error("link latch not reloaded after read");
endmodule // phy_control_status_regs

// file: src/phy_regs_map.svh
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH

// ----------------------------------------------------------------
// Register indices on the management interface
// ----------------------------------------------------------------
`define REG_PORT_CONTROL 5'h00
`define REG_PORT_BASIC_STATUS 5'h01

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define CTL_NEG_ENABLE 12
`define CTL_ISOLATE 10
`define CTL_NEG_RESTART 9
`define CTL_DUPLEX 8
`define CTL_COL_TEST 7

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define STS_FOUR_PAIR 15
`define STS_FAST_FD 14
`define STS_FAST_HD 13
`define STS_TEN_FD 12
`define STS_TEN_HD 11
`define STS_PRE_SUPPRESS 6
`define STS_NEG_COMPLETE 5
`define STS_FAR_FAULT 4
`define STS_NEG_ABILITY 3
`define STS_LINK_UP 2
`define STS_JABBER 1
`define STS_EXT_REGS 0

// ----------------------------------------------------------------
// Management frame constants
// ----------------------------------------------------------------
`define MDIO_PREAMBLE_LEN 32
`define MDIO_ADDR_BITS 4'h9
`define MDIO_LAST_BIT 4'hF
`define MDIO_TA_FIRST 4'h0
`define PIN_SYNC_WIDTH 9

`endif

// file: src/phy_regs_pkg.sv
package phy_regs_pkg;

    // Gray sequence along the frame path
    typedef enum logic [2:0] {
        FR_IDLE = 3'h0,
        FR_START = 3'h1,
        FR_OPCODE = 3'h3,
        FR_ADDR = 3'h2,
        FR_TURN = 3'h6,
        FR_DATA = 3'h7
    } frame_state_t;

    typedef enum logic [1:0] {
        OP_WRITE = 2'h1,
        OP_READ = 2'h2
    } mdio_op_t;

endpackage

// file: src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    pin_sync_if.sync pins // Raw pins in, synchronised levels out
);
    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    if (W < 1) begin : g_bad_width
        $error("pin_sync width must be at least one");
    end

    // Stage one feeds stage two only
    // Runs through reset on purpose: straps are caught from these stages while reset is held
    always_ff @(posedge clk) begin
        stage1_r <= pins.raw;
        stage2_r <= stage1_r;
    end

    assign pins.synced = stage2_r;
endmodule // pin_sync

// file: src/pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport source (output raw, input synced);
    modport sync (input raw, output synced);
endinterface // pin_sync_if

// file: tb/mdio_master.sv
`timescale 1ns/1ps
module mdio_master (
    input wire logic clk, // System clock
    input wire logic mdioWire, // Resolved data line
    output logic mdc, // Management clock
    output logic mdioDrv, // Data driven by us
    output logic mdioDrvOe // Our drive enable
);
    initial begin
        mdc = 1'b0;
        mdioDrv = 1'b1;
        mdioDrvOe = 1'b0;
    end
    // Drive in the low phase, sample just before the rise
    task automatic cyc(input logic b, input logic oe, output logic s);
        @(negedge clk);
        mdc = 1'b0;
        mdioDrv = b;
        mdioDrvOe = oe;
        repeat (8) @(negedge clk);
        s = mdioWire;
        mdc = 1'b1;
        repeat (7) @(negedge clk);
    endtask
    // Whole frame; on reads the line is released from the turnaround on
    task automatic frame(input logic rd, input logic [4:0] ph, input logic [4:0] ra,
            input logic [15:0] wd, output logic [15:0] rv);
        logic [63:0] v;
        logic s;
        v = {32'hFFFFFFFF, 2'b01, rd, !rd, ph, ra, 2'b10, wd};
        rv = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            cyc(v[i], !rd || i >= 18, s);
            if (i < 16) rv[i] = s;
        end
        // Clock stands still between frames
        @(negedge clk);
        mdc = 1'b0;
        mdioDrvOe = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule // mdio_master

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [15:0] wd; logic [15:0] rd; logic drv; logic fd;} row_t;
    logic clk, rst_b, mdc, mdioDrv, mdioDrvOe, mdioOut, mdioOe, mdioWire;
    logic strapAutoEn, strapFullDup, linkValid, remoteFault, jabberDetect;
    logic negDoneIn, negRestartedIn, anFullDuplexIn, transmitEnableIn;
    logic negotiationRestartReq, negotiationEnableOut, fullDuplexOut, collisionOut, miiDriveEn;
    logic [15:0] junk;
    int miscompares = 0;
    int check_count = 0;
    row_t rows[4] = '{'{16'h047F, 16'h0400, 1'b0, 1'b0}, '{16'h0100, 16'h0100, 1'b1, 1'b1},
        '{16'h1100, 16'h1100, 1'b1, 1'b0}, '{16'h0080, 16'h0080, 1'b1, 1'b0}};
    // Released line floats to the pull-up level
    assign mdioWire = mdioOe ? mdioOut : (mdioDrvOe ? mdioDrv : 1'b1);
    mdio_master mdio_master_i (.clk(clk), .mdioWire(mdioWire), .mdc(mdc), .mdioDrv(mdioDrv),
        .mdioDrvOe(mdioDrvOe));
    phy_control_status_regs phy_control_status_regs_i (.clk(clk), .rst_b(rst_b), .mdc(mdc),
        .mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddrStrap(5'h05),
        .strapAutoEn(strapAutoEn), .strapFullDup(strapFullDup), .linkValid(linkValid),
        .remoteFault(remoteFault), .jabberDetect(jabberDetect), .negDoneIn(negDoneIn),
        .negRestartedIn(negRestartedIn), .anFullDuplexIn(anFullDuplexIn),
        .transmitEnableIn(transmitEnableIn), .negotiationRestartReq(negotiationRestartReq),
        .negotiationEnableOut(negotiationEnableOut), .fullDuplexOut(fullDuplexOut),
        .collisionOut(collisionOut), .miiDriveEn(miiDriveEn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        mdio_master_i.frame(1'b0, 5'h05, ra, d, junk);
    endtask
    task automatic rdc(input logic [4:0] ra, input logic [15:0] e, input string n);
        mdio_master_i.frame(1'b1, 5'h05, ra, 16'h0000, junk);
        chk(n, e, junk);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = ~s;
        @(negedge clk);
        s = ~s;
    endtask
    task automatic stop_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Run is about 25k cycles; a hang is cut well beyond that
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_b, strapFullDup, linkValid, remoteFault, jabberDetect} = 5'h00;
        {negDoneIn, negRestartedIn, anFullDuplexIn, transmitEnableIn} = 4'h0;
        strapAutoEn = 1'b1;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk("negEnable", 16'h0001, {15'h0000, negotiationEnableOut});
        rdc(5'h01, 16'h7849, "status");
        rdc(5'h00, 16'h1000, "control");
        rdc(5'h02, 16'h0000, "unmapped");
        foreach (rows[i]) begin
            wr(5'h00, rows[i].wd);
            rdc(5'h00, rows[i].rd, "control");
            chk("driveEn", {15'h0000, rows[i].drv}, {15'h0000, miiDriveEn});
            chk("duplex", {15'h0000, rows[i].fd}, {15'h0000, fullDuplexOut});
            transmitEnableIn = 1'b1;
            repeat (3) @(negedge clk);
            chk("collision", {15'h0000, rows[i].wd[7]}, {15'h0000, collisionOut});
            transmitEnableIn = 1'b0;
        end
        strapFullDup = 1'b1;
        repeat (6) @(negedge clk);
        chk("duplex", 16'h0001, {15'h0000, fullDuplexOut});
        strapFullDup = 1'b0;
        // Frame for another port address must be ignored
        mdio_master_i.frame(1'b0, 5'h06, 5'h00, 16'h0400, junk);
        rdc(5'h00, 16'h0080, "control");
        pulse(negDoneIn);
        linkValid = 1'b1;
        rdc(5'h01, 16'h7869, "status");
        wr(5'h00, 16'h1200);
        chk("restartReq", 16'h0001, {15'h0000, negotiationRestartReq});
        rdc(5'h00, 16'h1200, "control");
        rdc(5'h01, 16'h784D, "status");
        pulse(negRestartedIn);
        repeat (4) @(negedge clk);
        chk("restartReq", 16'h0000, {15'h0000, negotiationRestartReq});
        rdc(5'h00, 16'h1000, "control");
        pulse(linkValid);
        pulse(remoteFault);
        jabberDetect = 1'b1;
        rdc(5'h01, 16'h785B, "status");
        jabberDetect = 1'b0;
        rdc(5'h01, 16'h784F, "status");
        rdc(5'h01, 16'h784D, "status");
        // Mid-run reset with the strap low; latched state must not survive it
        wr(5'h00, 16'h0500);
        pulse(negDoneIn);
        pulse(remoteFault);
        strapAutoEn = 1'b0;
        rst_b = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk("negEnable", 16'h0000, {15'h0000, negotiationEnableOut});
        chk("driveEn", 16'h0001, {15'h0000, miiDriveEn});
        chk("duplex", 16'h0000, {15'h0000, fullDuplexOut});
        rdc(5'h00, 16'h0000, "control");
        rdc(5'h01, 16'h7849, "status");
        stop_test();
    end
endmodule // testbench
